// file: inc/channel_offset_gain_pkg.sv
package channel_offset_gain_pkg;
    typedef logic [3:0] addr_t;
    typedef logic [15:0] word_t;
    typedef logic [11:0] offset_level_t;
    typedef logic [14:0] range_level_t;
endpackage

// file: inc/channel_offset_gain_regs.svh
`ifndef CHANNEL_OFFSET_GAIN_REGS_SVH
`define CHANNEL_OFFSET_GAIN_REGS_SVH

// ----------------------------------------
// Word addresses
// ----------------------------------------
`define ADDR_RESERVED_CONFIG 4'h1
`define ADDR_ICHAN_OFFSET 4'h2
`define ADDR_ICHAN_RANGE 4'h3

// ----------------------------------------
// Power-on values
// ----------------------------------------
`define RST_RESERVED_CONFIG 16'h2A0E
`define RST_ICHAN_OFFSET 16'h0000
`define RST_ICHAN_RANGE 16'h4000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OFS_POLARITY_BIT 12
`define OFS_LEVEL_MSB 11
`define OFS_RSVD_LSB 13
`define RNG_LEVEL_MSB 14
`define RNG_RSVD_BIT 15
`define MONO_BITS 9

// ----------------------------------------
// Nominal settings outside extended control
// ----------------------------------------
`define OFS_LEVEL_NOMINAL 12'h000
`define RNG_LEVEL_NOMINAL 15'h4000

`endif

// file: rtl/cfg_word_reg.sv
`timescale 1ns/1ps
module cfg_word_reg #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic we,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] q,
    output logic [WIDTH-1:0] q_nxt
);
    logic [WIDTH-1:0] q_r;

    // ----------------------------------------
    // Next value
    // ----------------------------------------
    always_comb begin
        q_nxt = q_r;
        if (ce && we) begin
            q_nxt = wdata;
        end
    end

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r <= RESET_VALUE;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule

// file: rtl/channel_offset_gain_regs.sv
// Functional notes
// - Reserved word powers up 2A0E, rewrite same
// - Offset bit 12 selects negative polarity
// - Offset bits 11:0 are unsigned magnitude
// - Offset monotonic only in nine MSBs
// - Range bits 14:0 magnitude, bit 15 zero
// - Range word powers up at 4000
// - Range monotonic nine MSBs, mid equals nominal
// - Range above default only in extended mode
`timescale 1ns/1ps
`include "channel_offset_gain_regs.svh"
module channel_offset_gain_regs (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire channel_offset_gain_pkg::addr_t addr,
    input wire channel_offset_gain_pkg::word_t wr_data,
    input wire logic extended_control_mode,
    output channel_offset_gain_pkg::word_t rd_data,
    output logic rd_valid,
    output logic reserved_ok,
    output logic offset_polarity,
    output channel_offset_gain_pkg::offset_level_t offset_level,
    output logic [`MONO_BITS-1:0] offset_coarse,
    output channel_offset_gain_pkg::range_level_t range_level,
    output logic [`MONO_BITS-1:0] range_coarse
);
    import channel_offset_gain_pkg::*;

    // ----------------------------------------
    // Register words
    // ----------------------------------------
    word_t rsvd_q;
    word_t rsvd_nxt;
    word_t ofs_q;
    word_t ofs_nxt;
    word_t rng_q;
    word_t rng_nxt;
    logic we_rsvd;
    logic we_ofs;
    logic we_rng;

    assign we_rsvd = wr_en && (addr == `ADDR_RESERVED_CONFIG);
    assign we_ofs = wr_en && (addr == `ADDR_ICHAN_OFFSET);
    assign we_rng = wr_en && (addr == `ADDR_ICHAN_RANGE);

    cfg_word_reg #(.WIDTH(16), .RESET_VALUE(`RST_RESERVED_CONFIG)) u_rsvd (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .we(we_rsvd),
        .wdata(wr_data),
        .q(rsvd_q),
        .q_nxt(rsvd_nxt)
    );

    // Bits 15:13 are stored as written; the analog side never looks at them
    cfg_word_reg #(.WIDTH(16), .RESET_VALUE(`RST_ICHAN_OFFSET)) u_ofs (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .we(we_ofs),
        .wdata(wr_data),
        .q(ofs_q),
        .q_nxt(ofs_nxt)
    );

    cfg_word_reg #(.WIDTH(16), .RESET_VALUE(`RST_ICHAN_RANGE)) u_rng (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .we(we_rng),
        .wdata(wr_data),
        .q(rng_q),
        .q_nxt(rng_nxt)
    );

    // ----------------------------------------
    // Applied settings and read-back
    // ----------------------------------------
    logic offset_polarity_r;
    logic offset_polarity_nxt;
    offset_level_t offset_level_r;
    offset_level_t offset_level_nxt;
    range_level_t range_level_r;
    range_level_t range_level_nxt;
    logic reserved_ok_r;
    logic reserved_ok_nxt;
    word_t rd_data_r;
    word_t rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;

    // Applied values follow the next register value so a write lands in one edge
    always_comb begin
        offset_polarity_nxt = offset_polarity_r;
        offset_level_nxt = offset_level_r;
        range_level_nxt = range_level_r;
        reserved_ok_nxt = reserved_ok_r;
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = rd_valid_r;
        if (ce) begin
            reserved_ok_nxt = (rsvd_nxt == `RST_RESERVED_CONFIG);
            if (extended_control_mode) begin
                offset_polarity_nxt = ofs_nxt[`OFS_POLARITY_BIT];
                offset_level_nxt = ofs_nxt[`OFS_LEVEL_MSB:0];
                range_level_nxt = rng_nxt[`RNG_LEVEL_MSB:0];
            end else begin
                // Nominal settings; the mid range code equals this nominal one
                offset_polarity_nxt = 1'b0;
                offset_level_nxt = `OFS_LEVEL_NOMINAL;
                range_level_nxt = `RNG_LEVEL_NOMINAL;
            end
            rd_valid_nxt = rd_en;
            if (rd_en) begin
                case (addr)
                    `ADDR_RESERVED_CONFIG: rd_data_nxt = rsvd_q;
                    `ADDR_ICHAN_OFFSET: rd_data_nxt = ofs_q;
                    `ADDR_ICHAN_RANGE: rd_data_nxt = rng_q;
                    default: rd_data_nxt = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset_polarity_r <= 1'b0;
            offset_level_r <= `OFS_LEVEL_NOMINAL;
            range_level_r <= `RNG_LEVEL_NOMINAL;
            reserved_ok_r <= 1'b1;
            rd_data_r <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else begin
            offset_polarity_r <= offset_polarity_nxt;
            offset_level_r <= offset_level_nxt;
            range_level_r <= range_level_nxt;
            reserved_ok_r <= reserved_ok_nxt;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign offset_polarity = offset_polarity_r;
    assign offset_level = offset_level_r;
    // Only the upper bits are monotonic, so trim loops should steer on these
    assign offset_coarse = offset_level_r[`OFS_LEVEL_MSB -: `MONO_BITS];
    assign range_level = range_level_r;
    assign range_coarse = range_level_r[`RNG_LEVEL_MSB -: `MONO_BITS];
    assign reserved_ok = reserved_ok_r;
    assign rd_data = rd_data_r;
    assign rd_valid = rd_valid_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    logic started_r;
    logic started_nxt;

    always_comb begin
        started_nxt = 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            started_r <= 1'b0;
        end else begin
            started_r <= started_nxt;
        end
    end

    a_range_por_value: assert property (@(posedge clk) disable iff (!nrst)
        !started_r |-> (rng_q == `RST_ICHAN_RANGE && rsvd_q == `RST_RESERVED_CONFIG))
        else $error("range or reserved word not at power-on value");

    a_reserved_match: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_rsvd |=> reserved_ok == ($past(wr_data) == `RST_RESERVED_CONFIG))
        else $error("reserved word check wrong after write");

    a_offset_sign_apply: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_ofs && extended_control_mode |=> offset_polarity == $past(wr_data[12]))
        else $error("offset polarity not applied");

    a_offset_level_apply: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_ofs && extended_control_mode |=> offset_level == $past(wr_data[11:0]))
        else $error("offset magnitude not applied");

    a_offset_coarse_tie: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_ofs && extended_control_mode |=> offset_coarse == $past(wr_data[11:3]))
        else $error("offset coarse bits wrong");

    a_range_level_apply: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_rng && extended_control_mode |=> range_level == $past(wr_data[14:0]))
        else $error("range magnitude not applied");

    a_range_coarse_tie: assert property (@(posedge clk) disable iff (!nrst)
        ce && we_rng && extended_control_mode |=> range_coarse == $past(wr_data[14:6]))
        else $error("range coarse bits wrong");

    a_range_nominal_only: assert property (@(posedge clk) disable iff (!nrst)
        ce && !extended_control_mode |=> range_level == `RNG_LEVEL_NOMINAL)
        else $error("range above nominal outside extended mode");

    a_offset_nominal_only: assert property (@(posedge clk) disable iff (!nrst)
        ce && !extended_control_mode |=> (offset_level == 12'h000 && !offset_polarity)[*1] ##1
        (!$past(ce) || $past(extended_control_mode) || offset_level == 12'h000))
        else $error("offset applied outside extended mode");

    a_read_back: assert property (@(posedge clk) disable iff (!nrst)
        ce && rd_en && addr == `ADDR_ICHAN_OFFSET |=> rd_valid && rd_data == $past(ofs_q))
        else $error("offset word read-back wrong");
endmodule

// file: sim/channel_offset_gain_regs_tb_top.sv
`timescale 1ns/1ps
module channel_offset_gain_regs_tb_top;
    import channel_offset_gain_pkg::*;
    logic clk, nrst, ce, wr_en, rd_en, extended_control_mode, rd_valid, reserved_ok, offset_polarity, vld;
    addr_t addr;
    word_t wr_data, rd_data, got;
    offset_level_t offset_level;
    range_level_t range_level;
    logic [8:0] offset_coarse, range_coarse;
    int failures = 0;
    int compares = 0;
    // ------------------------------
    // Instances
    // ------------------------------
    channel_offset_gain_regs channel_offset_gain_regs_i (.clk(clk), .nrst(nrst), .ce(ce), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .extended_control_mode(extended_control_mode),
        .rd_data(rd_data), .rd_valid(rd_valid), .reserved_ok(reserved_ok), .offset_polarity(offset_polarity),
        .offset_level(offset_level), .offset_coarse(offset_coarse), .range_level(range_level),
        .range_coarse(range_coarse));
    reg_host_model reg_host_model_i (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data), .ce(ce),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
    // ------------------------------
    // Check tasks
    // ------------------------------
    task automatic chk(input word_t g, input word_t e);
        compares++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic rdchk(input addr_t a, input word_t e);
        reg_host_model_i.rd(a, got, vld);
        chk({15'h0, vld}, 16'h0001);
        chk(got, e);
    endtask
    // Coarse fields are the monotonic top nine bits of each level
    task automatic outs(input logic p, input logic [11:0] o, input logic [14:0] r);
        chk({15'h0, offset_polarity}, {15'h0, p});
        chk({4'h0, offset_level}, {4'h0, o});
        chk({7'h0, offset_coarse}, {7'h0, o[11:3]});
        chk({1'b0, range_level}, {1'b0, r});
        chk({7'h0, range_coarse}, {7'h0, r[14:6]});
    endtask
    // ------------------------------
    // Stimulus
    // ------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #20000;
        failures++;
        end_sim();
    end
    initial begin
        nrst = 1'b0;
        extended_control_mode = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        nrst = 1'b1;
        chk({15'h0, reserved_ok}, 16'h0001);
        outs(1'b0, 12'h000, 15'h4000);
        rdchk(4'h1, 16'h2A0E);
        rdchk(4'h2, 16'h0000);
        rdchk(4'h3, 16'h4000);
        rdchk(4'hF, 16'h0000);
        reg_host_model_i.wr(4'h2, 16'h1005, 1'b1);
        reg_host_model_i.wr(4'h3, 16'h7FFF, 1'b1);
        outs(1'b0, 12'h000, 15'h4000);
        extended_control_mode = 1'b1;
        @(posedge clk);
        #1;
        outs(1'b1, 12'h005, 15'h7FFF);
        reg_host_model_i.wr(4'h2, 16'hEFFF, 1'b1);
        outs(1'b0, 12'hFFF, 15'h7FFF);
        reg_host_model_i.wr(4'h3, 16'h0000, 1'b0);
        rdchk(4'h3, 16'h7FFF);
        reg_host_model_i.wr(4'h3, 16'h8000, 1'b1);
        outs(1'b0, 12'hFFF, 15'h0000);
        rdchk(4'h2, 16'h0FFF);
        reg_host_model_i.wr(4'h1, 16'h1234, 1'b1);
        chk({15'h0, reserved_ok}, 16'h0001);
        rdchk(4'h1, 16'h2A0E);
        end_sim();
    end
endmodule

// file: sim/reg_host_model.sv
`timescale 1ns/1ps
module reg_host_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire channel_offset_gain_pkg::word_t rd_data,
    output logic ce,
    output logic wr_en,
    output logic rd_en,
    output channel_offset_gain_pkg::addr_t addr,
    output channel_offset_gain_pkg::word_t wr_data
);
    import channel_offset_gain_pkg::*;
    // ------------------------------
    // Host access tasks
    // ------------------------------
    initial begin
        ce = 1'b1;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 4'h0;
        wr_data = 16'h0000;
    end
    // Idle bus shows inverted values so stale data never looks valid
    task automatic wr(input addr_t a, input word_t d, input logic c);
        word_t v;
        v = d;
        if (a == 4'h1) v = 16'h2A0E;
        if (a == 4'h2) v[15:13] = 3'h0;
        if (a == 4'h3) v[15] = 1'b0;
        @(posedge clk);
        #1;
        ce = c;
        wr_en = 1'b1;
        addr = a;
        wr_data = v;
        @(posedge clk);
        #1;
        ce = 1'b1;
        wr_en = 1'b0;
        addr = ~a;
        wr_data = ~v;
    endtask
    task automatic rd(input addr_t a, output word_t d, output logic v);
        @(posedge clk);
        #1;
        rd_en = 1'b1;
        addr = a;
        @(posedge clk);
        #1;
        rd_en = 1'b0;
        addr = ~a;
        d = rd_data;
        v = rd_valid;
    endtask
endmodule
